// ### psro_pkg.sv
package psro_pkg;

	// ****************************************
	// Instruction, bank and type codes.
	// ****************************************
	localparam logic [7:0]  INS_STORE     = 8'h0B;
	localparam logic [7:0]  INS_RESTORE   = 8'h0C;
	localparam logic [7:0]  INS_REFSEARCH = 8'h0D;
	localparam logic [7:0]  INS_SETOUT    = 8'h0E;
	localparam logic [7:0]  INS_GETIN     = 8'h0F;
	localparam logic [7:0]  BANK_GLOBAL   = 8'h00;
	localparam logic [7:0]  BANK_USER     = 8'h02;
	localparam logic [7:0]  RFS_START     = 8'h00;
	localparam logic [7:0]  RFS_STOP      = 8'h01;
	localparam logic [7:0]  RFS_STATUS    = 8'h02;
	localparam logic [7:0]  PORT_ALL      = 8'hFF;
	localparam logic [31:0] VAL_FROM_ACCU = 32'hFFFF_FFFF;

	// ****************************************
	// Reply status codes and framing.
	// ****************************************
	localparam logic [7:0]  ST_OK         = 8'h64;
	localparam logic [7:0]  ST_BAD_CSUM   = 8'h01;
	localparam logic [7:0]  ST_BAD_CMD    = 8'h02;
	localparam logic [7:0]  ST_BAD_TYPE   = 8'h03;
	localparam logic [7:0]  ST_BAD_VAL    = 8'h04;
	localparam logic [3:0]  FRAME_LAST    = 4'h8;
	localparam logic [3:0]  DOUT_RESET    = 4'h0;
	localparam int          OUT_LINES     = 4;

	// ****************************************
	// Register offsets.
	// ****************************************
	localparam logic [7:0]  REG_CMD_BYTE  = 8'h00;
	localparam logic [7:0]  REG_REPLY     = 8'h04;
	localparam logic [7:0]  REG_STATUS    = 8'h08;
	localparam logic [7:0]  REG_ACCU      = 8'h0C;
	localparam logic [7:0]  REG_VAR_SEL   = 8'h10;
	localparam logic [7:0]  REG_VAR_DATA  = 8'h14;
	localparam logic [7:0]  REG_OUTPUTS   = 8'h18;

	// ****************************************
	// Timing.
	// ****************************************
	localparam int          CLK_PERIOD_NS  = 5;
	localparam int          SEARCH_TIME_NS = 5000;
	localparam int          SEARCH_CYCLES  = SEARCH_TIME_NS / CLK_PERIOD_NS;

	// Sum of eight bytes modulo 256.
	function automatic logic [7:0] psro_csum(input logic [63:0] b);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 8; i++) begin
			s = s + b[8*i +: 8];
		end
		return s;
	endfunction : psro_csum

endpackage : psro_pkg

// ### psro_frame_rx.sv
`timescale 1ns/1ps
module psro_frame_rx (
	// Clock and reset.
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// Incoming command bytes.
	input  wire logic        byte_valid,
	input  wire logic [7:0]  byte_data,
	// Assembled frame.
	output logic             frame_valid,
	output logic [63:0]      frame_body,
	output logic             frame_csum_ok
);
	import psro_pkg::*;

	logic [3:0] cnt_q;

	// ****************************************
	// Byte assembly in arrival order.
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			cnt_q         <= 4'h0;
			frame_valid   <= 1'b0;
			frame_csum_ok <= 1'b0;
			frame_body    <= 64'h0000_0000_0000_0000;
		end else begin
			frame_valid <= 1'b0;
			if (byte_valid) begin
				if (cnt_q == FRAME_LAST) begin
					cnt_q         <= 4'h0;
					frame_valid   <= 1'b1;
					frame_csum_ok <= (psro_csum(frame_body) == byte_data); // [R17]
				end else begin
					cnt_q      <= cnt_q + 4'h1;
					frame_body <= {frame_body[55:0], byte_data}; // [R14]
				end
			end
		end
	end

	AST_RX_PULSE : assert property (@(posedge clk_sys) disable iff (!resetn)
		frame_valid |=> !frame_valid) // [R14]
		else $error("frame valid held longer than one cycle");

endmodule : psro_frame_rx

// ### psro_param_nv.sv
`timescale 1ns/1ps
module psro_param_nv #(
	parameter int NUM_VARS = 16
) (
	// Clock and reset.
	input  wire logic                        clk_sys,
	input  wire logic                        resetn,
	// Live write port.
	input  wire logic                        wr_en,
	input  wire logic [$clog2(NUM_VARS):0]   wr_addr,
	input  wire logic [31:0]                 wr_data,
	// Store and restore.
	input  wire logic                        store_en,
	input  wire logic                        restore_en,
	input  wire logic [$clog2(NUM_VARS):0]   op_addr,
	// Read port.
	input  wire logic [$clog2(NUM_VARS):0]   rd_addr,
	output logic [31:0]                      rd_data,
	output logic                             loading
);
	import psro_pkg::*;

	localparam int AW       = $clog2(NUM_VARS) + 1;
	localparam int LOAD_MAX = 2 * NUM_VARS;

	logic [31:0]   live_q [2*NUM_VARS];
	logic [31:0]   nv_q   [2*NUM_VARS];
	logic [AW-1:0] lptr_q;

	assign rd_data = live_q[rd_addr];

	// ****************************************
	// Power-up reload, then live updates.
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			loading <= 1'b1;
			lptr_q  <= '0;
		end else if (loading) begin
			lptr_q <= lptr_q + AW'(1);
			if (lptr_q == AW'(LOAD_MAX - 1)) begin
				loading <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (resetn && loading) begin
			live_q[lptr_q] <= nv_q[lptr_q]; // [R5]
		end
		if (restore_en) begin
			live_q[op_addr] <= nv_q[op_addr]; // [R4]
		end else if (wr_en) begin
			live_q[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (store_en) begin
			nv_q[op_addr] <= live_q[op_addr]; // [R1]
		end
		if (wr_en && !wr_addr[AW-1]) begin
			nv_q[wr_addr] <= wr_data; // [R3]
		end
	end

	AST_STORE : assert property (@(posedge clk_sys) disable iff (!resetn) // [R1]
		store_en && !wr_en |=> nv_q[$past(op_addr)] == $past(live_q[op_addr]))
		else $error("store did not copy live value");
	AST_AUTO_STORE : assert property (@(posedge clk_sys) disable iff (!resetn) // [R3]
		wr_en && !wr_addr[AW-1] && !store_en |=> nv_q[$past(wr_addr)] == $past(wr_data))
		else $error("global write not kept nonvolatile");
	AST_RESTORE : assert property (@(posedge clk_sys) disable iff (!resetn) // [R4]
		restore_en |=> live_q[$past(op_addr)] == $past(nv_q[op_addr]))
		else $error("restore did not reload value");
	AST_AUTOLOAD : assert property (@(posedge clk_sys) disable iff (!resetn) // [R5]
		loading |-> ##[0:LOAD_MAX] !loading)
		else $error("power-up reload did not finish");

endmodule : psro_param_nv

// ### psro_cmd_core.sv
`timescale 1ns/1ps
// Summary of operation
// [R1] Store command copies selected parameter to nonvolatile.
// [R2] Host addresses user variables through bank two.
// [R3] Bank zero writes are kept nonvolatile automatically.
// [R4] Restore command reloads variable from nonvolatile copy.
// [R5] All variables reload automatically after reset.
// [R6] Search type: 0 start, 1 stop, 2 status.
// [R7] One search state machine per axis.
// [R8] Status query: zero idle, nonzero while running.
// [R9] Store, restore, start, stop reply 100, value 0.
// [R10] Set-output drives selected line to 0 or 1.
// [R11] Four output lines, ports 0-3, bank two.
// [R12] Port 255 sets all lines from bit vector.
// [R13] Value -1 takes the vector from accumulator.
// [R14] Host sends nine bytes, value most significant first.
// [R15] Reply framed with addresses, status, echo, value, checksum.
// [R16] Get-input bank two reads back output states.
// [R17] Checksum is byte sum; bad checksum rejected.
// [R18] Outputs low after reset until set.
module psro_cmd_core #(
	parameter logic [7:0] MODULE_ADDR   = 8'h01,
	parameter logic [7:0] HOST_ADDR     = 8'h02,
	parameter int         NUM_AXES      = 3,
	parameter int         NUM_VARS      = 16,
	parameter int         SEARCH_CYCLES = psro_pkg::SEARCH_CYCLES
) (
	// Clock and reset.
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// Register port.
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	// Digital outputs.
	output logic             digital_out_line_0,
	output logic             digital_out_line_1,
	output logic             digital_out_line_2,
	output logic             digital_out_line_3
);
	import psro_pkg::*;

	localparam int IW  = $clog2(NUM_VARS);
	localparam int AXW = (NUM_AXES > 1) ? $clog2(NUM_AXES) : 1;
	localparam int SW  = 16;

	// ****************************************
	// Declarations.
	// ****************************************
	logic                 frame_valid;
	logic [63:0]          frame_body;
	logic                 frame_csum_ok;
	logic [7:0]           fr_addr;
	logic [7:0]           fr_ins;
	logic [7:0]           fr_typ;
	logic [7:0]           fr_bank;
	logic [31:0]          fr_value;
	logic                 exec;
	logic [AXW-1:0]       ax_idx;
	logic [7:0]           st_c;
	logic [31:0]          val_c;
	logic [OUT_LINES-1:0] dout_d;
	logic [OUT_LINES-1:0] dout_q;
	logic                 store_c;
	logic                 restore_c;
	logic [NUM_AXES-1:0]  start_c;
	logic [NUM_AXES-1:0]  stop_c;
	logic [SW-1:0]        srch_cnt_q [NUM_AXES];
	logic [NUM_AXES-1:0]  srch_act;
	logic [7:0]           reply_q [9];
	logic [7:0]           rep_c [9];
	logic [3:0]           rptr_q;
	logic                 ravail_q;
	logic [31:0]          accu_q;
	logic [IW:0]          sel_q;
	logic [31:0]          var_rd;
	logic                 loading;
	logic                 rx_byte;
	logic                 var_wr;
	logic                 reply_pop;

	assign fr_addr  = frame_body[63:56];
	assign fr_ins   = frame_body[55:48];
	assign fr_typ   = frame_body[47:40];
	assign fr_bank  = frame_body[39:32];
	assign fr_value = frame_body[31:0];
	assign exec     = frame_valid && (fr_addr == MODULE_ADDR);
	assign ax_idx   = fr_bank[AXW-1:0];
	assign rx_byte  = reg_wr && (reg_addr == REG_CMD_BYTE);
	assign var_wr   = reg_wr && (reg_addr == REG_VAR_DATA);
	assign reply_pop = reg_rd && (reg_addr == REG_REPLY) && ravail_q;

	// Parameter select: bank 2 is the upper half, bank 0 the lower half.
	function automatic logic [IW:0] param_addr(input logic [7:0] bank, input logic [7:0] idx);
		return {bank == BANK_USER, idx[IW-1:0]};
	endfunction : param_addr

	function automatic logic param_ok(input logic [7:0] bank, input logic [7:0] idx);
		return ((bank == BANK_USER) || (bank == BANK_GLOBAL)) && (idx < 8'(NUM_VARS));
	endfunction : param_ok

	// ****************************************
	// Submodules.
	// ****************************************
	psro_frame_rx u_rx (
		.clk_sys       (clk_sys),
		.resetn        (resetn),
		.byte_valid    (rx_byte),
		.byte_data     (reg_wdata[7:0]),
		.frame_valid   (frame_valid),
		.frame_body    (frame_body),
		.frame_csum_ok (frame_csum_ok)
	);

	psro_param_nv #(
		.NUM_VARS (NUM_VARS)
	) u_nv (
		.clk_sys    (clk_sys),
		.resetn     (resetn),
		.wr_en      (var_wr),
		.wr_addr    (sel_q),
		.wr_data    (reg_wdata),
		.store_en   (store_c && exec),
		.restore_en (restore_c && exec),
		.op_addr    (param_addr(fr_bank, fr_typ)),
		.rd_addr    (sel_q),
		.rd_data    (var_rd),
		.loading    (loading)
	);

	// ****************************************
	// Command decode.
	// ****************************************
	always_comb begin
		st_c      = ST_OK;
		val_c     = 32'h0000_0000; // [R9]
		dout_d    = dout_q;
		store_c   = 1'b0;
		restore_c = 1'b0;
		start_c   = '0;
		stop_c    = '0;
		if (!frame_csum_ok) begin
			st_c = ST_BAD_CSUM; // [R17]
		end else begin
			unique case (fr_ins)
				INS_STORE, INS_RESTORE: begin
					if (!param_ok(fr_bank, fr_typ)) begin
						st_c = ST_BAD_VAL; // [R2]
					end else if (fr_ins == INS_STORE) begin
						store_c = 1'b1; // [R1]
					end else begin
						restore_c = 1'b1; // [R4]
					end
				end
				INS_REFSEARCH: begin
					if (fr_bank >= 8'(NUM_AXES)) begin
						st_c = ST_BAD_VAL;
					end else if (fr_typ == RFS_START) begin
						start_c[ax_idx] = 1'b1; // [R6]
					end else if (fr_typ == RFS_STOP) begin
						stop_c[ax_idx] = 1'b1; // [R6]
					end else if (fr_typ == RFS_STATUS) begin
						val_c = {16'h0000, srch_cnt_q[ax_idx]}; // [R8]
					end else begin
						st_c = ST_BAD_TYPE;
					end
				end
				INS_SETOUT: begin
					if (fr_bank != BANK_USER) begin
						st_c = ST_BAD_VAL; // [R11]
					end else if (fr_typ == PORT_ALL) begin
						if (fr_value == VAL_FROM_ACCU) begin
							dout_d = accu_q[OUT_LINES-1:0]; // [R13]
						end else begin
							dout_d = fr_value[OUT_LINES-1:0]; // [R12]
						end
					end else if (fr_typ >= 8'(OUT_LINES)) begin
						st_c = ST_BAD_TYPE; // [R11]
					end else if (fr_value > 32'h0000_0001) begin
						st_c = ST_BAD_VAL; // [R11]
					end else begin
						dout_d[fr_typ[1:0]] = fr_value[0]; // [R10]
					end
				end
				INS_GETIN: begin
					if (fr_bank != BANK_USER) begin
						st_c = ST_BAD_VAL;
					end else if (fr_typ == PORT_ALL) begin
						val_c = {28'h000_0000, dout_q}; // [R16]
					end else if (fr_typ < 8'(OUT_LINES)) begin
						val_c = {31'h0000_0000, dout_q[fr_typ[1:0]]}; // [R16]
					end else begin
						st_c = ST_BAD_TYPE;
					end
				end
				default: begin
					st_c = ST_BAD_CMD;
				end
			endcase
		end
	end

	// ****************************************
	// Outputs.
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			dout_q <= DOUT_RESET; // [R18]
		end else if (exec) begin
			dout_q <= dout_d; // [R10]
		end
	end

	assign digital_out_line_0 = dout_q[0];
	assign digital_out_line_1 = dout_q[1];
	assign digital_out_line_2 = dout_q[2];
	assign digital_out_line_3 = dout_q[3];

	// ****************************************
	// Reference search per axis.
	// ****************************************
	always_ff @(posedge clk_sys) begin
		for (int a = 0; a < NUM_AXES; a++) begin
			if (!resetn) begin
				srch_cnt_q[a] <= '0;
			end else if (exec && start_c[a]) begin
				srch_cnt_q[a] <= SW'(SEARCH_CYCLES); // [R7]
			end else if (exec && stop_c[a]) begin
				srch_cnt_q[a] <= '0; // [R7]
			end else if (srch_cnt_q[a] != '0) begin
				srch_cnt_q[a] <= srch_cnt_q[a] - SW'(1);
			end
		end
	end

	always_comb begin
		for (int a = 0; a < NUM_AXES; a++) begin
			srch_act[a] = (srch_cnt_q[a] != '0);
		end
	end

	// ****************************************
	// Reply frame.
	// ****************************************
	always_comb begin
		rep_c[0] = HOST_ADDR; // [R15]
		rep_c[1] = MODULE_ADDR;
		rep_c[2] = st_c;
		rep_c[3] = fr_ins;
		rep_c[4] = val_c[31:24];
		rep_c[5] = val_c[23:16];
		rep_c[6] = val_c[15:8];
		rep_c[7] = val_c[7:0];
		rep_c[8] = psro_csum({rep_c[0], rep_c[1], rep_c[2], rep_c[3],
			rep_c[4], rep_c[5], rep_c[6], rep_c[7]}); // [R17]
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			ravail_q <= 1'b0;
			rptr_q   <= 4'h0;
			for (int i = 0; i < 9; i++) begin
				reply_q[i] <= 8'h00;
			end
		end else if (exec) begin
			ravail_q <= 1'b1;
			rptr_q   <= 4'h0;
			for (int i = 0; i < 9; i++) begin
				reply_q[i] <= rep_c[i]; // [R15]
			end
		end else if (reply_pop) begin
			rptr_q <= rptr_q + 4'h1;
			if (rptr_q == FRAME_LAST) begin
				ravail_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Register port.
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			accu_q <= 32'h0000_0000;
			sel_q  <= '0;
		end else if (reg_wr) begin
			if (reg_addr == REG_ACCU) begin
				accu_q <= reg_wdata;
			end
			if (reg_addr == REG_VAR_SEL) begin
				sel_q <= param_addr(reg_wdata[15:8], reg_wdata[7:0]);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				REG_REPLY:    reg_rdata <= {24'h00_0000, ravail_q ? reply_q[rptr_q] : 8'h00};
				REG_STATUS:   reg_rdata <= 32'({srch_act, loading, ravail_q});
				REG_ACCU:     reg_rdata <= accu_q;
				REG_VAR_DATA: reg_rdata <= var_rd;
				REG_OUTPUTS:  reg_rdata <= {28'h000_0000, dout_q}; // [R16]
				default:      reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// ****************************************
	// Checks.
	// ****************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	logic sio_ok_c;
	assign sio_ok_c = exec && frame_csum_ok && fr_ins == INS_SETOUT && fr_bank == BANK_USER;

	AST_SIO_SINGLE : assert property ( // [R10]
		sio_ok_c && fr_typ < 8'(OUT_LINES) && fr_value <= 32'h0000_0001
		|=> dout_q[$past(fr_typ[1:0])] == $past(fr_value[0]))
		else $error("single output not set");
	AST_SIO_ALL : assert property ( // [R12]
		sio_ok_c && fr_typ == PORT_ALL && fr_value != VAL_FROM_ACCU
		|=> dout_q == $past(fr_value[3:0]))
		else $error("output vector not applied");
	AST_SIO_ACCU : assert property ( // [R13]
		sio_ok_c && fr_typ == PORT_ALL && fr_value == VAL_FROM_ACCU
		|=> dout_q == $past(accu_q[3:0]))
		else $error("accumulator vector not applied");
	AST_REPLY_OK : assert property ( // [R9]
		exec && frame_csum_ok && fr_ins == INS_STORE && param_ok(fr_bank, fr_typ)
		|=> reply_q[2] == ST_OK && {reply_q[4], reply_q[5], reply_q[6], reply_q[7]} == 32'h0)
		else $error("store reply wrong");
	AST_BAD_CSUM : assert property ( // [R17]
		exec && !frame_csum_ok |=> reply_q[2] == ST_BAD_CSUM && $stable(dout_q))
		else $error("bad checksum frame not rejected");
	AST_REPLY_CSUM : assert property ( // [R15]
		ravail_q |-> reply_q[8] == psro_csum({reply_q[0], reply_q[1], reply_q[2],
			reply_q[3], reply_q[4], reply_q[5], reply_q[6], reply_q[7]}) && reply_q[0] == HOST_ADDR)
		else $error("reply frame malformed");
	AST_RFS_RUN : assert property ( // [R7]
		exec && start_c[0] |=> srch_act[0] [*3])
		else $error("search not running after start");
	AST_RFS_STATUS : assert property ( // [R8]
		exec && frame_csum_ok && fr_ins == INS_REFSEARCH && fr_typ == RFS_STATUS && fr_bank == 8'h00
		|=> ({reply_q[6], reply_q[7]} == 16'h0000) == !$past(srch_act[0]))
		else $error("search status value wrong");
	AST_DOUT_RESET : assert property ( // [R18]
		$rose(resetn) |-> dout_q == DOUT_RESET)
		else $error("outputs not low after reset");

	COV_SEARCH : cover property (exec && start_c[0] ##[1:200] exec && stop_c[0]);
	COV_SIO_ALL : cover property (sio_ok_c && fr_typ == PORT_ALL);
	COV_BAD_CSUM : cover property (exec && !frame_csum_ok);

endmodule : psro_cmd_core

// ### psro_host_model.sv
`timescale 1ns/1ps
module psro_host_model (
	// Clock.
	input  wire logic        clk_sys,
	// Register port toward the block.
	output logic [7:0]       reg_addr,
	output logic [31:0]      reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd,
	input  wire logic [31:0] reg_rdata
);
	import psro_pkg::*;

	initial begin
		reg_addr  = 8'h0;
		reg_wdata = 32'h0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
	end

	// ****************************************
	// Bus cycles.
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		reg_addr <= ~a;
		@(posedge clk_sys);
		d = reg_rdata;
	endtask : rd

	// ****************************************
	// Command frames.
	// ****************************************
	task automatic cmd(input logic [7:0] tgt, ins, typ, bank, input logic [31:0] val,
			input logic bad);
		logic [7:0] b [9];
		logic [7:0] s;
		b = '{tgt, ins, typ, bank, val[31:24], val[23:16], val[15:8], val[7:0], 8'h0};
		s = 8'h0;
		for (int i = 0; i < 8; i++) begin
			s = s + b[i];
		end
		b[8] = s + {7'h0, bad};
		for (int i = 0; i < 9; i++) begin
			wr(REG_CMD_BYTE, {24'h0, b[i]});
		end
	endtask : cmd

	task automatic reply(output logic [7:0] r [9]);
		logic [31:0] d;
		d = 32'h0;
		for (int i = 0; i < 20 && d[0] !== 1'b1; i++) begin
			rd(REG_STATUS, d);
		end
		for (int i = 0; i < 9; i++) begin
			rd(REG_REPLY, d);
			r[i] = d[7:0];
		end
	endtask : reply

endmodule : psro_host_model

// ### psro_cmd_core_tb.sv
`timescale 1ns/1ps
module psro_cmd_core_tb;
	import psro_pkg::*;

	localparam int SC = 200;

	typedef struct {
		logic [7:0]  ins;
		logic [7:0]  typ;
		logic [7:0]  bank;
		logic [31:0] val;
		logic [7:0]  st;
		logic [31:0] rv;
		bit          nz;
		logic [3:0]  out;
	} psro_row_t;

	logic        clk_sys;
	logic        resetn;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic [3:0]  dout;
	logic [31:0] d;
	logic [7:0]  r [9];
	int          errors;
	int          check_count;

	psro_row_t rows [17] = '{
		'{INS_SETOUT, 8'h0, BANK_USER, 32'h1, ST_OK, 32'h0, 0, 4'h1},
		'{INS_SETOUT, 8'h3, BANK_USER, 32'h1, ST_OK, 32'h0, 0, 4'h9},
		'{INS_SETOUT, 8'h0, BANK_USER, 32'h0, ST_OK, 32'h0, 0, 4'h8},
		'{INS_GETIN, 8'h3, BANK_USER, 32'h0, ST_OK, 32'h1, 0, 4'h8},
		'{INS_SETOUT, 8'h1, BANK_USER, 32'h2, ST_BAD_VAL, 32'h0, 0, 4'h8},
		'{INS_SETOUT, 8'h4, BANK_USER, 32'h1, ST_BAD_TYPE, 32'h0, 0, 4'h8},
		'{INS_SETOUT, 8'h0, BANK_GLOBAL, 32'h1, ST_BAD_VAL, 32'h0, 0, 4'h8},
		'{INS_SETOUT, PORT_ALL, BANK_USER, 32'h6, ST_OK, 32'h0, 0, 4'h6},
		'{INS_GETIN, PORT_ALL, BANK_USER, 32'h0, ST_OK, 32'h6, 0, 4'h6},
		'{INS_REFSEARCH, RFS_START, 8'h0, 32'h0, ST_OK, 32'h0, 0, 4'h6},
		'{INS_REFSEARCH, RFS_STATUS, 8'h0, 32'h0, ST_OK, 32'h0, 1, 4'h6},
		'{INS_REFSEARCH, RFS_STOP, 8'h0, 32'h0, ST_OK, 32'h0, 0, 4'h6},
		'{INS_REFSEARCH, RFS_STATUS, 8'h0, 32'h0, ST_OK, 32'h0, 0, 4'h6},
		'{INS_REFSEARCH, 8'h3, 8'h1, 32'h0, ST_BAD_TYPE, 32'h0, 0, 4'h6},
		'{INS_REFSEARCH, RFS_START, 8'h3, 32'h0, ST_BAD_VAL, 32'h0, 0, 4'h6},
		'{INS_STORE, 8'h10, BANK_USER, 32'h0, ST_BAD_VAL, 32'h0, 0, 4'h6},
		'{8'h07, 8'h0, BANK_USER, 32'h0, ST_BAD_CMD, 32'h0, 0, 4'h6}
	};

	psro_cmd_core #(.SEARCH_CYCLES(SC)) uut (
		.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.digital_out_line_0(dout[0]), .digital_out_line_1(dout[1]),
		.digital_out_line_2(dout[2]), .digital_out_line_3(dout[3])
	);

	psro_host_model host (
		.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
	);

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// ****************************************
	// Comparison and verdict.
	// ****************************************
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test

	task automatic exec(input logic [7:0] ins, typ, bank, input logic [31:0] val,
			input logic [7:0] st, input logic [31:0] rv, input bit nz);
		logic [7:0]  s;
		logic [31:0] v;
		host.cmd(8'h01, ins, typ, bank, val, 1'b0);
		host.reply(r);
		s = 8'h0;
		for (int i = 0; i < 8; i++) begin
			s = s + r[i];
		end
		v = {r[4], r[5], r[6], r[7]};
		chk("reply host", {24'h0, r[0]}, 32'h2);
		chk("reply target", {24'h0, r[1]}, 32'h1);
		chk("reply status", {24'h0, r[2]}, {24'h0, st});
		chk("reply instr", {24'h0, r[3]}, {24'h0, ins});
		chk("reply csum", {24'h0, r[8]}, {24'h0, s});
		if (nz) begin
			chk("reply busy", {31'h0, v != 32'h0}, 32'h1);
		end else begin
			chk("reply value", v, rv);
		end
	endtask : exec

	initial begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		finish_test();
	end

	// ****************************************
	// Test sequence.
	// ****************************************
	initial begin
		errors      = 0;
		check_count = 0;
		resetn      = 1'b0;
		repeat (12) @(posedge clk_sys);
		chk("reset outputs", {28'h0, dout}, 32'h0);
		resetn <= 1'b1;
		foreach (rows[i]) begin
			exec(rows[i].ins, rows[i].typ, rows[i].bank, rows[i].val, rows[i].st, rows[i].rv,
				rows[i].nz);
			chk("outputs", {28'h0, dout}, {28'h0, rows[i].out});
		end
		host.wr(REG_VAR_SEL, 32'h205);
		host.wr(REG_VAR_DATA, 32'hA5A5_0001);
		exec(INS_STORE, 8'h05, BANK_USER, 32'h0, ST_OK, 32'h0, 0);
		host.wr(REG_VAR_DATA, 32'hBEEF);
		host.rd(REG_VAR_DATA, d);
		chk("live var", d, 32'hBEEF);
		exec(INS_RESTORE, 8'h05, BANK_USER, 32'h0, ST_OK, 32'h0, 0);
		host.rd(REG_VAR_DATA, d);
		chk("restored var", d, 32'hA5A5_0001);
		host.wr(REG_VAR_SEL, 32'h7);
		host.wr(REG_VAR_DATA, 32'h1234_5678);
		exec(INS_RESTORE, 8'h07, BANK_GLOBAL, 32'h0, ST_OK, 32'h0, 0);
		host.rd(REG_VAR_DATA, d);
		chk("bank zero var", d, 32'h1234_5678);
		host.wr(REG_ACCU, 32'h9);
		exec(INS_SETOUT, PORT_ALL, BANK_USER, VAL_FROM_ACCU, ST_OK, 32'h0, 0);
		chk("accu outputs", {28'h0, dout}, 32'h9);
		host.rd(REG_OUTPUTS, d);
		chk("outputs reg", d, 32'h9);
		host.cmd(8'h01, INS_SETOUT, 8'h0, BANK_USER, 32'h0, 1'b1);
		host.reply(r);
		chk("bad csum status", {24'h0, r[2]}, {24'h0, ST_BAD_CSUM});
		chk("bad csum outputs", {28'h0, dout}, 32'h9);
		host.cmd(8'h05, INS_SETOUT, 8'h0, BANK_USER, 32'h0, 1'b0);
		repeat (10) @(posedge clk_sys);
		host.rd(REG_STATUS, d);
		chk("foreign frame reply", {31'h0, d[0]}, 32'h0);
		chk("foreign frame outputs", {28'h0, dout}, 32'h9);
		host.wr(8'h1C, 32'hFFFF_FFFF);
		host.rd(8'h1C, d);
		chk("unmapped read", d, 32'h0);
		exec(INS_REFSEARCH, RFS_START, 8'h2, 32'h0, ST_OK, 32'h0, 0);
		repeat (SC + 20) @(posedge clk_sys);
		exec(INS_REFSEARCH, RFS_STATUS, 8'h2, 32'h0, ST_OK, 32'h0, 0);
		host.wr(REG_VAR_SEL, 32'h205);
		host.wr(REG_VAR_DATA, 32'h1111);
		@(posedge clk_sys);
		resetn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("second reset outputs", {28'h0, dout}, 32'h0);
		resetn <= 1'b1;
		d = 32'hFFFF_FFFF;
		for (int i = 0; i < 30 && d[1] !== 1'b0; i++) begin
			host.rd(REG_STATUS, d);
		end
		host.wr(REG_VAR_SEL, 32'h205);
		host.rd(REG_VAR_DATA, d);
		chk("reloaded var", d, 32'hA5A5_0001);
		finish_test();
	end

endmodule : psro_cmd_core_tb
